// ### hdl/lab_top.v
// Logic, arithmetic and branch unit with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lab_defines.vh"
module lab_top (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Write address
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// Write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// Write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// Read address
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// Read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	////////////////////////////////////////////////////////////////////
	// Architectural state
	reg [15:0] instr_q;
	reg [15:0] src_q;
	reg [15:0] dst_q;
	reg [15:0] pc_q;
	reg [3:0] flags_q;
	reg [15:0] result_q;
	reg wrote_q;
	reg taken_q;
	reg illegal_q;
	reg [15:0] res_w;
	wire [15:0] alu_res;
	wire [3:0] alu_flags;
	wire alu_wr;
	wire [15:0] alu_pc;
	wire alu_taken;
	wire alu_legal;
	// Execution runs from the registers as they stand
	lab_alu u_alu (
		.instr(instr_q),
		.src(src_q),
		.dst(dst_q),
		.pc(pc_q),
		.flags_in(flags_q),
		.result(alu_res),
		.flags_out(alu_flags),
		.write_dst(alu_wr),
		.pc_next(alu_pc),
		.taken(alu_taken),
		.legal(alu_legal)
	);
	////////////////////////////////////////////////////////////////////
	// Write channel capture
	reg aw_hold_q;
	reg [11:0] aw_addr_q;
	reg w_hold_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	// Writing CTRL loads the instruction and fires execution next cycle
	reg exec_q;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	// Held off while executing, so a fast master cannot lose a write
	wire do_write = aw_hold_q && w_hold_q && !s_axi_bvalid && !exec_q;
	wire [11:0] aw_word = {aw_addr_q[11:2], 2'b00};
	// Byte lanes of the low half; upper strobes have no register bits
	wire [15:0] wlow;
	wire [15:0] wkeep;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
			assign wlow[gi*8 +: 8] =
				w_data_q[gi*8 +: 8] & {8{w_strb_q[gi]}};
			assign wkeep[gi*8 +: 8] = {8{~w_strb_q[gi]}};
		end
	endgenerate
	wire hit_ctrl = (aw_word == `LAB_REG_CTRL);
	wire wr_ok = hit_ctrl ||
		(aw_word == `LAB_REG_SRC) ||
		(aw_word == `LAB_REG_DST) ||
		(aw_word == `LAB_REG_PC) ||
		(aw_word == `LAB_REG_FLAGS);
	reg aw_hold_d;
	reg [11:0] aw_addr_d;
	reg w_hold_d;
	reg [31:0] w_data_d;
	reg [3:0] w_strb_d;
	reg awready_d;
	reg wready_d;
	reg bvalid_d;
	reg [1:0] bresp_d;
	always @* begin
		aw_hold_d = aw_hold_q;
		aw_addr_d = aw_addr_q;
		w_hold_d = w_hold_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		awready_d = !aw_hold_q && !aw_take;
		wready_d = !w_hold_q && !w_take;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		if (aw_take) begin
			aw_hold_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (w_take) begin
			w_hold_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_ok ? `LAB_RESP_OKAY : `LAB_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LAB_RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Register updates and execution
	reg [15:0] instr_d;
	reg [15:0] src_d;
	reg [15:0] dst_d;
	reg [15:0] pc_d;
	reg [3:0] flags_d;
	reg [15:0] result_d;
	reg wrote_d;
	reg taken_d;
	reg illegal_d;
	always @* begin
		instr_d = instr_q;
		src_d = src_q;
		dst_d = dst_q;
		pc_d = pc_q;
		flags_d = flags_q;
		result_d = result_q;
		wrote_d = wrote_q;
		taken_d = taken_q;
		illegal_d = illegal_q;
		if (exec_q) begin
			// AND-test never touches dst
			if (alu_wr)
				dst_d = alu_res;
			// Branch result updates pc only
			pc_d = alu_pc;
			flags_d = alu_flags;
			result_d = alu_res;
			wrote_d = alu_wr;
			taken_d = alu_taken;
			illegal_d = !alu_legal;
		end else if (do_write) begin
			case (aw_word)
			`LAB_REG_CTRL:
				instr_d = (instr_q & wkeep) | wlow;
			`LAB_REG_SRC:
				src_d = (src_q & wkeep) | wlow;
			`LAB_REG_DST:
				dst_d = (dst_q & wkeep) | wlow;
			`LAB_REG_PC:
				pc_d = (pc_q & wkeep) | wlow;
			`LAB_REG_FLAGS:
				flags_d = (flags_q & wkeep[3:0]) | wlow[3:0];
			default: ;
			endcase
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			instr_q <= `LAB_RST_WORD;
			src_q <= `LAB_RST_WORD;
			dst_q <= `LAB_RST_WORD;
			pc_q <= `LAB_RST_WORD;
			flags_q <= `LAB_RST_FLAGS;
			result_q <= `LAB_RST_WORD;
			wrote_q <= 1'b0;
			taken_q <= 1'b0;
			illegal_q <= 1'b0;
			exec_q <= 1'b0;
		end else begin
			instr_q <= instr_d;
			src_q <= src_d;
			dst_q <= dst_d;
			pc_q <= pc_d;
			flags_q <= flags_d;
			result_q <= result_d;
			wrote_q <= wrote_d;
			taken_q <= taken_d;
			illegal_q <= illegal_d;
			exec_q <= do_write && hit_ctrl;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Read channel
	// Status bit 0 shows execution pending, so software can poll
	reg [31:0] rd_d;
	reg rd_ok;
	wire [11:0] ar_word = {s_axi_araddr[11:2], 2'b00};
	always @* begin
		rd_d = 32'h00000000;
		rd_ok = 1'b1;
		res_w = result_q;
		case (ar_word)
		`LAB_REG_CTRL: rd_d = {16'h0000, instr_q};
		`LAB_REG_SRC: rd_d = {16'h0000, src_q};
		`LAB_REG_DST: rd_d = {16'h0000, dst_q};
		`LAB_REG_PC: rd_d = {16'h0000, pc_q};
		`LAB_REG_FLAGS: rd_d = {28'h0000000, flags_q};
		`LAB_REG_RESULT: rd_d = {16'h0000, res_w};
		`LAB_REG_STATUS:
			rd_d = {28'h0000000, illegal_q, taken_q, wrote_q, exec_q};
		default: rd_ok = 1'b0;
		endcase
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LAB_RESP_OKAY;
		end else begin
			// One read at a time; ready drops while data waits
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_ok ? `LAB_RESP_OKAY : `LAB_RESP_SLVERR;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // lab_top
`default_nettype wire

// ### common/lab_defines.vh
// Constants for the logic, arithmetic and branch unit
`ifndef LAB_DEFINES_VH
`define LAB_DEFINES_VH
// Register byte offsets
`define LAB_REG_CTRL 12'h000
`define LAB_REG_SRC 12'h004
`define LAB_REG_DST 12'h008
`define LAB_REG_PC 12'h00c
`define LAB_REG_FLAGS 12'h010
`define LAB_REG_RESULT 12'h014
`define LAB_REG_STATUS 12'h018
// Instruction field positions
`define LAB_BYTE_BIT 15
`define LAB_OP_HI 14
`define LAB_OP_LO 12
`define LAB_BR_HI 15
`define LAB_BR_LO 8
// Double operand codes (bits 14:12)
`define LAB_OP_AND_TEST 3'h3
`define LAB_OP_CLR_MASK 3'h4
`define LAB_OP_OR_INTO 3'h5
`define LAB_OP_ADDSUB 3'h6
// Branch codes (bits 15:8)
`define LAB_BR_ALWAYS 8'h01
`define LAB_BR_NONZERO 8'h02
`define LAB_BR_ZERO 8'h03
`define LAB_BR_NOT_LESS 8'h04
// Flag bit positions
`define LAB_FLAG_C 0
`define LAB_FLAG_V 1
`define LAB_FLAG_Z 2
`define LAB_FLAG_N 3
// Reset values
`define LAB_RST_WORD 16'h0000
`define LAB_RST_FLAGS 4'h0
// AXI responses
`define LAB_RESP_OKAY 2'h0
`define LAB_RESP_SLVERR 2'h2
`endif

// ### hdl/lab_alu.v
// Combinational operate and branch evaluation core
`timescale 1ns/1ps
`default_nettype none
`include "lab_defines.vh"
module lab_alu (
	// Instruction and operands
	input wire [15:0] instr,
	input wire [15:0] src,
	input wire [15:0] dst,
	input wire [15:0] pc,
	input wire [3:0] flags_in,
	// Results
	output reg [15:0] result,
	output reg [3:0] flags_out,
	output reg write_dst,
	output reg [15:0] pc_next,
	output reg taken,
	output reg legal
);
	wire is_byte = instr[`LAB_BYTE_BIT];
	wire [2:0] op = instr[`LAB_OP_HI:`LAB_OP_LO];
	wire [7:0] br = instr[`LAB_BR_HI:`LAB_BR_LO];
	wire [16:0] sum = {1'b0, dst} + {1'b0, src};
	wire [16:0] diff = {1'b0, dst} + {1'b0, ~src} + 17'h00001;
	wire [15:0] target = pc + {{7{instr[7]}}, instr[7:0], 1'b0};
	reg [15:0] lres;
	reg lhit;
	always @* begin
		result = dst;
		flags_out = flags_in;
		write_dst = 1'b0;
		pc_next = pc;
		taken = 1'b0;
		legal = 1'b1;
		lres = 16'h0000;
		lhit = 1'b0;
		case (op)
		`LAB_OP_AND_TEST: begin
			lres = src & dst;
			lhit = 1'b1;
		end
		`LAB_OP_CLR_MASK: begin
			lres = dst & ~src;
			lhit = 1'b1;
			write_dst = 1'b1;
		end
		`LAB_OP_OR_INTO: begin
			lres = dst | src;
			lhit = 1'b1;
			write_dst = 1'b1;
		end
		`LAB_OP_ADDSUB: begin
			write_dst = 1'b1;
			if (!is_byte) begin
				result = sum[15:0];
				flags_out[`LAB_FLAG_V] = (src[15] == dst[15]) &&
					(sum[15] != dst[15]);
				flags_out[`LAB_FLAG_C] = sum[16];
			end else begin
				result = diff[15:0];
				flags_out[`LAB_FLAG_V] = (src[15] != dst[15]) &&
					(diff[15] == src[15]);
				flags_out[`LAB_FLAG_C] = ~diff[16];
			end
			flags_out[`LAB_FLAG_N] = result[15];
			flags_out[`LAB_FLAG_Z] = (result == 16'h0000);
		end
		3'h0: begin
			// Flags untouched on every branch
			case (br)
			`LAB_BR_ALWAYS: taken = 1'b1;
			`LAB_BR_NONZERO: taken = ~flags_in[`LAB_FLAG_Z];
			`LAB_BR_ZERO: taken = flags_in[`LAB_FLAG_Z];
			`LAB_BR_NOT_LESS: taken = ~(flags_in[`LAB_FLAG_N] ^
				flags_in[`LAB_FLAG_V]);
			default: legal = 1'b0;
			endcase
			if (taken)
				pc_next = target;
		end
		default: legal = 1'b0;
		endcase
		if (lhit) begin
			// Byte forms keep the upper dst byte intact
			if (is_byte) begin
				result = {dst[15:8], lres[7:0]};
				flags_out[`LAB_FLAG_N] = lres[7];
				flags_out[`LAB_FLAG_Z] = (lres[7:0] == 8'h00);
			end else begin
				result = lres;
				flags_out[`LAB_FLAG_N] = lres[15];
				flags_out[`LAB_FLAG_Z] = (lres == 16'h0000);
			end
			flags_out[`LAB_FLAG_V] = 1'b0;
		end
		if (!legal) begin
			result = dst;
			flags_out = flags_in;
			write_dst = 1'b0;
		end
	end
endmodule // lab_alu
`default_nettype wire

// ### sim/lab_top_assertions.sv
// Bus handshake checker for the logic, arithmetic and branch unit
`timescale 1ns/1ps
`default_nettype none
module lab_top_assertions (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write side
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read side
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer withdrawn");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
	a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken during answer");
	a_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_resp_legal: assert property (s_axi_bvalid |-> !s_axi_bresp[0]
		&& !(s_axi_rvalid && s_axi_rresp[0])) else $error("odd response code");
endmodule // lab_top_assertions
bind lab_top lab_top_assertions u_lab_top_assertions (.*);
`default_nettype wire

// ### sim/logic_arith_branch_unit_tb_top.sv
// Self-checking bench for the logic, arithmetic and branch unit
`timescale 1ns/1ps
`default_nettype none
`include "lab_defines.vh"
module logic_arith_branch_unit_tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [33:0] rq[$], x;
	logic [1:0] bq[$];
	logic [15:0] s, d, p, ins;
	logic [3:0] f;
	logic [35:0] e;
	int num_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [15:0] ops[12] = '{16'h3000, 16'hb000, 16'h4000, 16'hc000,
		16'h5000, 16'hd000, 16'h6000, 16'he000,
		16'h0100, 16'h0200, 16'h0300, 16'h0400};
	lab_top u_lab_top (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
		.s_axi_wstrb(4'hf));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input [33:0] seen, input [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Monitor; slave error data is undefined, so only its code counts
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_bvalid && s_axi_bready)
			chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
		if (s_axi_rvalid && s_axi_rready) begin
			x = rq.pop_front();
			chk({s_axi_rresp, x[33] ? 32'h0 : s_axi_rdata}, x);
		end
		if (cyc == 8000) begin
			num_errors++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input [11:0] a, input [15:0] v, input [1:0] r);
		bq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// A late bready makes the slave hold its answer
		s_axi_bready <= 1'($urandom);
		forever begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				break;
			if (s_axi_bvalid)
				s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input [11:0] a, input [33:0] v);
		rq.push_back(v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom);
		forever begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				break;
			if (s_axi_rvalid)
				s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
	endtask
	// Reference: {flags, dst, pc} after one instruction
	function automatic [35:0] model(input [15:0] i, s, d, p, input [3:0] f);
		logic [16:0] sm;
		logic [15:0] r;
		model = {f, d, p};
		case (i[14:12])
		3'h3, 3'h4, 3'h5: begin
			r = i[14:12] == 3'h3 ? s & d : i[14:12] == 3'h4 ? ~s & d : s | d;
			if (i[15])
				r = {d[15:8], r[7:0]};
			model[35:32] = {i[15] ? r[7] : r[15],
				i[15] ? r[7:0] == 8'h0 : r == 16'h0, 1'b0, f[0]};
			if (i[14:12] != 3'h3)
				model[31:16] = r;
		end
		3'h6: begin
			sm = {1'b0, d} + (i[15] ? {1'b0, ~s} + 17'h1 : {1'b0, s});
			r = sm[15:0];
			model[35:32] = {r[15], r == 16'h0, i[15] ?
				d[15] != s[15] && r[15] == s[15] :
				d[15] == s[15] && r[15] != s[15], sm[16] ^ i[15]};
			model[31:16] = r;
		end
		3'h0: if (i[15:8] == 8'h01 || (i[15:8] == 8'h02 && !f[2]) ||
			(i[15:8] == 8'h03 && f[2]) || (i[15:8] == 8'h04 && f[3] == f[1]))
			model[15:0] = p + {{7{i[7]}}, i[7:0], 1'b0};
		default: ;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		void'($urandom(12));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(12'(i * 4), 34'h0);
		$display("test reset_values done");
		// Equal operands every fifth trial; the byte clear-mask trial 15 then gives a zero low byte
		for (int i = 0; i < 48; i++) begin
			s = 16'($urandom);
			d = (i % 5 == 0) ? s : 16'($urandom);
			p = 16'($urandom);
			f = 4'($urandom);
			ins = i == 8 ? 16'h0180 : i == 20 ? 16'h017f : ops[i % 12];
			if (i % 12 > 8)
				ins[7:0] = 8'($urandom);
			e = model(ins, s, d, p, f);
			wr(`LAB_REG_SRC, s, `LAB_RESP_OKAY);
			wr(`LAB_REG_DST, d, `LAB_RESP_OKAY);
			wr(`LAB_REG_PC, p, `LAB_RESP_OKAY);
			wr(`LAB_REG_FLAGS, {12'h0, f}, `LAB_RESP_OKAY);
			wr(`LAB_REG_CTRL, ins, `LAB_RESP_OKAY);
			rd(`LAB_REG_DST, {18'h0, e[31:16]});
			rd(`LAB_REG_FLAGS, {30'h0, e[35:32]});
			rd(`LAB_REG_PC, {18'h0, e[15:0]});
			rd(`LAB_REG_SRC, {18'h0, s});
		end
		$display("test operations done");
		wr(`LAB_REG_SRC, 16'h00f0, `LAB_RESP_OKAY);
		wr(`LAB_REG_DST, 16'h0ff0, `LAB_RESP_OKAY);
		wr(`LAB_REG_CTRL, 16'h4000, `LAB_RESP_OKAY);
		rd(`LAB_REG_RESULT, 34'h0f00);
		rd(`LAB_REG_STATUS, 34'h2);
		// Unknown operation code leaves dst alone and flags it
		wr(`LAB_REG_CTRL, 16'h7000, `LAB_RESP_OKAY);
		rd(`LAB_REG_STATUS, 34'h8);
		rd(`LAB_REG_DST, 34'h0f00);
		$display("test status done");
		wr(12'h0fc, 16'h1, `LAB_RESP_SLVERR);
		wr(`LAB_REG_RESULT, 16'h1, `LAB_RESP_SLVERR);
		wr(`LAB_REG_STATUS, 16'h1, `LAB_RESP_SLVERR);
		rd(12'h0fc, {`LAB_RESP_SLVERR, 32'h0});
		repeat (4) @(posedge aclk);
		$display("test unmapped done");
		final_report();
	end
endmodule // logic_arith_branch_unit_tb_top
`default_nettype wire
